// >>> lock_gpi_cfg.svh
// Constants for the sector lock, input pin and device select block
`ifndef LOCK_GPI_CFG_SVH
`define LOCK_GPI_CFG_SVH
`define NUM_SECTORS 7
`define LOCK_DEFAULT 8'h01
`define LOCK_BIT_WRITE 0
`define LOCK_BIT_DOWN 1
`define LOCK_BIT_READ 2
`define LOCK_FIELD_MASK 8'h07
`define LOCK_REG_LOW 13'h0002
`define INPUT_PIN_LOW 18'h00100
`define INPUT_PIN_OFFSET 32'hffbc0100
`define REG_SEL_BIT_HUB 22
`define REG_SEL_BIT_PLAIN 23
`define READ_BLOCK_DATA 8'h00
`define START_PLAIN 4'h0
`define START_HUB_READ 4'hd
`define START_HUB_WRITE 4'he
`define CYCTYPE_MEM 2'b01
`define SYNC_READY 4'h0
`define TAR_DRIVE 4'hf
`define ADDR_NIBBLES_HUB 3'h6
`define ADDR_NIBBLES_PLAIN 3'h7
`endif

// >>> lock_gpi_pkg.sv
// Types for the sector lock, input pin and device select block
package lock_gpi_pkg;
  typedef enum logic [9:0] {
    ST_IDLE    = 10'b0000000001,
    ST_START   = 10'b0000000010,
    ST_ADDR    = 10'b0000000100,
    ST_MSIZE   = 10'b0000001000,
    ST_WDATA   = 10'b0000010000,
    ST_TAR_IN  = 10'b0000100000,
    ST_SYNC    = 10'b0001000000,
    ST_RDATA   = 10'b0010000000,
    ST_TAR_OUT = 10'b0100000000,
    ST_IGNORE  = 10'b1000000000
  } cyc_state_t;
endpackage

// >>> sector_lock_gpi_device_select.sv
// Bus cycle decoder with sector locking, input pin register and device select
// How it works
// - Lock-down bits come up cleared after power-up.
// - Lock-down sets once; later writes to that locking register are ignored.
// - While locked down, read-block and write-block bits hold their values.
// - Lock-down clears only on reset pin, init or power-up.
// - Bit 2 blocks reads; blocked reads return 00H.
// - Bit 0 blocks program and erase, set by default; bus write cycles still reach the array.
// - Bit 1 is lock-down; bits 7:3 reserved; frozen until reset.
// - 07H blocked frozen, 02H open frozen, 00H open unfrozen.
// - 06H read-blocked frozen, 05H both blocked unfrozen, 04H read-blocked.
// - Locking registers default to 01H; 03H is write-blocked and frozen.
// - Input-pin register is read-only and returns live levels of five inputs.
// - Bit n follows general input n; bits 7:5 reserved.
// - Hub cycles compare straps to select field; mismatch ignores the cycle.
// - On mismatch lines are released; standby when frame high, decoder idle or ignoring, and array not busy.
// - Up to 16 devices; select field equals strap pattern in binary.
// - Program or erase on a write-blocked sector is refused and flagged.
// - Register space selected by A22 in hub mode, A23 in plain mode.
`timescale 1ns/100ps
`include "lock_gpi_cfg.svh"
`default_nettype none

module sector_lock_gpi_device_select
  import lock_gpi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_init_n,
  input wire logic i_frame_strobe_n,
  input wire logic [3:0] i_muxed_addr_data_lines,
  output logic [3:0] o_muxed_addr_data_lines,
  output logic o_muxed_addr_data_oe_n,
  input wire logic [3:0] i_device_select_straps,
  input wire logic [4:0] i_general_inputs,
  input wire logic [7:0] i_array_rdata,
  input wire logic i_array_busy,
  output logic [17:0] o_array_addr,
  output logic [7:0] o_array_wdata,
  output logic o_array_wr,
  input wire logic i_pe_req,
  input wire logic [2:0] i_pe_sector,
  output logic o_pe_refused,
  output logic o_lock_error,
  input wire logic i_lock_error_clr,
  output logic o_standby
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Frame and data share the same two-stage delay so nibbles stay aligned
  logic [1:0] frame_sync_reg;
  logic [3:0] lad_s1_reg, lad_s2_reg;
  logic [3:0] strap_s1_reg, strap_s2_reg;
  logic [4:0] gpi_s1_reg, gpi_s2_reg;
  logic [1:0] init_sync_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_sync_reg <= 2'h3;
      lad_s1_reg <= 4'hf;
      lad_s2_reg <= 4'hf;
      strap_s1_reg <= 4'h0;
      strap_s2_reg <= 4'h0;
      gpi_s1_reg <= 5'h00;
      gpi_s2_reg <= 5'h00;
      init_sync_reg <= 2'h3;
    end else begin
      frame_sync_reg <= {frame_sync_reg[0], i_frame_strobe_n};
      lad_s1_reg <= i_muxed_addr_data_lines;
      lad_s2_reg <= lad_s1_reg;
      strap_s1_reg <= i_device_select_straps;
      strap_s2_reg <= strap_s1_reg;
      gpi_s1_reg <= i_general_inputs;
      gpi_s2_reg <= gpi_s1_reg;
      init_sync_reg <= {init_sync_reg[0], i_init_n};
    end
  end

  logic frame_n;
  logic init_active;
  assign frame_n = frame_sync_reg[1];
  assign init_active = !init_sync_reg[1];

  // ------------------------------------------------------------
  // Cycle state machine
  // ------------------------------------------------------------
  cyc_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [3:0] start_reg, start_next;
  logic hub_reg, hub_next;
  logic wr_reg, wr_next;
  logic [31:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [3:0] lad_out_reg, lad_out_next;
  logic oe_n_reg, oe_n_next;
  logic access;

  logic [2:0] sector;
  logic reg_space;
  logic lock_hit;
  logic gpi_hit;
  logic [7:0] lock_reg [`NUM_SECTORS];

  always_comb begin
    sector = 3'h0;
    if (addr_reg[17:14] == 4'hf) begin
      sector = 3'h6;
    end else if (addr_reg[17:13] == 5'h1d) begin
      sector = 3'h5;
    end else if (addr_reg[17:13] == 5'h1c) begin
      sector = 3'h4;
    end else if (addr_reg[17:15] == 3'h6) begin
      sector = 3'h3;
    end else begin
      sector = {1'b0, addr_reg[17:16]};
    end
  end

  // Register space is the low half of the window; the select bit moves by mode
  assign reg_space = hub_reg ? !addr_reg[`REG_SEL_BIT_HUB] : !addr_reg[`REG_SEL_BIT_PLAIN];
  assign lock_hit = reg_space && (addr_reg[12:0] == `LOCK_REG_LOW);
  assign gpi_hit = reg_space && (addr_reg[17:0] == `INPUT_PIN_LOW);
  assign access = (state_reg == ST_TAR_IN) && (cnt_reg == 3'h0);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    start_next = start_reg;
    hub_next = hub_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    if (!frame_n) begin
      // A new frame always restarts the decoder, even mid-cycle
      state_next = ST_START;
      start_next = lad_s2_reg;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_START: begin
          addr_next = 32'h0;
          if (start_reg == `START_HUB_READ || start_reg == `START_HUB_WRITE) begin
            hub_next = 1'b1;
            wr_next = (start_reg == `START_HUB_WRITE);
            if (lad_s2_reg == strap_s2_reg) begin
              state_next = ST_ADDR;
              cnt_next = `ADDR_NIBBLES_HUB;
            end else begin
              state_next = ST_IGNORE;
            end
          end else if (start_reg == `START_PLAIN && lad_s2_reg[3:2] == `CYCTYPE_MEM) begin
            hub_next = 1'b0;
            wr_next = lad_s2_reg[1];
            state_next = ST_ADDR;
            cnt_next = `ADDR_NIBBLES_PLAIN;
          end else begin
            state_next = ST_IGNORE;
          end
        end
        ST_ADDR: begin
          addr_next = {addr_reg[27:0], lad_s2_reg};
          cnt_next = cnt_reg - 3'h1;
          if (cnt_reg == 3'h0) begin
            cnt_next = 3'h1;
            if (hub_reg) begin
              state_next = ST_MSIZE;
            end else begin
              state_next = wr_reg ? ST_WDATA : ST_TAR_IN;
            end
          end
        end
        ST_MSIZE: begin
          cnt_next = 3'h1;
          state_next = wr_reg ? ST_WDATA : ST_TAR_IN;
        end
        ST_WDATA: begin
          // Low nibble first
          wdata_next = {lad_s2_reg, wdata_reg[7:4]};
          cnt_next = cnt_reg - 3'h1;
          if (cnt_reg == 3'h0) begin
            cnt_next = 3'h1;
            state_next = ST_TAR_IN;
          end
        end
        ST_TAR_IN: begin
          cnt_next = cnt_reg - 3'h1;
          if (cnt_reg == 3'h0) begin
            state_next = ST_SYNC;
            if (gpi_hit) begin
              rdata_next = {3'h0, gpi_s2_reg};
            end else if (lock_hit) begin
              rdata_next = lock_reg[sector];
            end else if (reg_space) begin
              rdata_next = 8'h00;
            end else if (lock_reg[sector][`LOCK_BIT_READ]) begin
              rdata_next = `READ_BLOCK_DATA;
            end else begin
              rdata_next = i_array_rdata;
            end
          end
        end
        ST_SYNC: begin
          cnt_next = 3'h1;
          state_next = wr_reg ? ST_TAR_OUT : ST_RDATA;
        end
        ST_RDATA: begin
          rdata_next = {4'h0, rdata_reg[7:4]};
          cnt_next = cnt_reg - 3'h1;
          if (cnt_reg == 3'h0) begin
            state_next = ST_TAR_OUT;
          end
        end
        ST_TAR_OUT: begin
          state_next = ST_IDLE;
        end
        ST_IGNORE: begin
          // Rest of a foreign cycle is dropped until the next frame
          state_next = ST_IGNORE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Output drive follows the next state so pins change with the state
  always_comb begin
    lad_out_next = `TAR_DRIVE;
    oe_n_next = 1'b1;
    case (state_next)
      ST_SYNC: begin
        lad_out_next = `SYNC_READY;
        oe_n_next = 1'b0;
      end
      ST_RDATA: begin
        lad_out_next = rdata_next[3:0];
        oe_n_next = 1'b0;
      end
      ST_TAR_OUT: begin
        lad_out_next = `TAR_DRIVE;
        oe_n_next = 1'b0;
      end
      default: begin
        lad_out_next = `TAR_DRIVE;
        oe_n_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      start_reg <= 4'hf;
      hub_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 32'h0;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      lad_out_reg <= 4'hf;
      oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      start_reg <= start_next;
      hub_reg <= hub_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      lad_out_reg <= lad_out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // ------------------------------------------------------------
  // Sector locking registers
  // ------------------------------------------------------------
  logic lock_wr;
  assign lock_wr = access && wr_reg && lock_hit;

  genvar g;
  generate
    for (g = 0; g < `NUM_SECTORS; g++) begin : g_lock
      logic [7:0] lk_reg, lk_next;
      always_comb begin
        lk_next = lk_reg;
        if (init_active) begin
          lk_next = `LOCK_DEFAULT;
        end else if (lock_wr && sector == 3'(g) && !lk_reg[`LOCK_BIT_DOWN]) begin
          // Full 3-bit code table taken as written; reserved bits dropped
          lk_next = wdata_reg & `LOCK_FIELD_MASK;
        end
      end
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          lk_reg <= `LOCK_DEFAULT;
        end else begin
          lk_reg <= lk_next;
        end
      end
      assign lock_reg[g] = lk_reg;
    end
  endgenerate

  // ------------------------------------------------------------
  // Array side and program/erase guard
  // ------------------------------------------------------------
  logic wr_pulse_reg, wr_pulse_next;
  logic refused_reg, refused_next;
  logic err_reg, err_next;

  always_comb begin
    wr_pulse_next = access && wr_reg && !reg_space;
    refused_next = i_pe_req && lock_reg[i_pe_sector][`LOCK_BIT_WRITE];
    err_next = err_reg;
    if (i_lock_error_clr) begin
      err_next = 1'b0;
    end
    // A refusal in the clearing cycle still sets the flag
    if (refused_next) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_pulse_reg <= 1'b0;
      refused_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      wr_pulse_reg <= wr_pulse_next;
      refused_reg <= refused_next;
      err_reg <= err_next;
    end
  end

  assign o_muxed_addr_data_lines = lad_out_reg;
  assign o_muxed_addr_data_oe_n = oe_n_reg;
  assign o_array_addr = addr_reg[17:0];
  assign o_array_wdata = wdata_reg;
  assign o_array_wr = wr_pulse_reg;
  assign o_pe_refused = refused_reg;
  assign o_lock_error = err_reg;
  assign o_standby = frame_n && !i_array_busy &&
                     (state_reg == ST_IDLE || state_reg == ST_IGNORE);

endmodule

`default_nettype wire

// >>> lock_gpi_monitor.sv
// Checker for the sector lock, input pin and device select block
`timescale 1ns/100ps
`default_nettype none
module lock_gpi_monitor (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_frame_strobe_n,
  input wire logic [3:0] i_muxed_addr_data_lines,
  input wire logic [3:0] o_muxed_addr_data_lines,
  input wire logic o_muxed_addr_data_oe_n,
  input wire logic [3:0] i_device_select_straps,
  input wire logic i_array_busy,
  input wire logic o_array_wr,
  input wire logic i_pe_req,
  input wire logic o_pe_refused,
  input wire logic o_lock_error,
  input wire logic i_lock_error_clr,
  input wire logic o_standby
);
  // ----------------------------------------
  // Select nibble snooped at the pins
  // ----------------------------------------
  // Decoder state is hidden, so the cycle kind is rebuilt from the wire
  logic frame_q, hub_q;
  logic [3:0] start_q, sel_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_q <= 1'b0;
      hub_q <= 1'b0;
      start_q <= 4'h0;
      sel_q <= 4'h0;
    end else begin
      frame_q <= !i_frame_strobe_n;
      if (!i_frame_strobe_n) start_q <= i_muxed_addr_data_lines;
      if (frame_q && i_frame_strobe_n) begin
        hub_q <= (start_q == 4'hd) || (start_q == 4'he);
        sel_q <= i_muxed_addr_data_lines;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_refusal_flags; o_pe_refused |-> o_lock_error; endproperty
  a_refusal_flags: assert property (p_refusal_flags) else $error("refusal without flag");
  property p_refusal_cause; o_pe_refused |-> $past(i_pe_req); endproperty
  a_refusal_cause: assert property (p_refusal_cause) else $error("refusal without req");
  property p_error_fall; $fell(o_lock_error) |-> $past(i_lock_error_clr); endproperty
  a_error_fall: assert property (p_error_fall) else $error("lock error lost");
  property p_clear; $past(i_lock_error_clr) && !o_pe_refused |-> !o_lock_error; endproperty
  a_clear: assert property (p_clear) else $error("lock error not cleared");
  property p_sel_drive;
    $fell(o_muxed_addr_data_oe_n) |-> !hub_q || (sel_q == i_device_select_straps);
  endproperty
  a_sel_drive: assert property (p_sel_drive) else $error("answered foreign select");
  property p_sel_wr; o_array_wr |-> !hub_q || (sel_q == i_device_select_straps); endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("wrote on foreign select");
  // Standby must also mean the shared lines are let go
  property p_standby; o_standby |-> !i_array_busy && o_muxed_addr_data_oe_n; endproperty
  a_standby: assert property (p_standby) else $error("standby while busy");
  property p_hold; $fell(o_muxed_addr_data_oe_n) |-> ##[2:4] $rose(o_muxed_addr_data_oe_n);
  endproperty
  a_hold: assert property (p_hold) else $error("lines not released");
  property p_release_f; $rose(o_muxed_addr_data_oe_n) |-> $past(o_muxed_addr_data_lines) == 4'hf;
  endproperty
  a_release_f: assert property (p_release_f) else $error("no f before release");
endmodule
bind sector_lock_gpi_device_select lock_gpi_monitor i_mon (.i_clk, .i_rstn, .i_frame_strobe_n,
  .i_muxed_addr_data_lines, .o_muxed_addr_data_lines, .o_muxed_addr_data_oe_n,
  .i_device_select_straps, .i_array_busy, .o_array_wr, .i_pe_req, .o_pe_refused,
  .o_lock_error, .i_lock_error_clr, .o_standby);
`default_nettype wire

// >>> lpc_host_model.sv
// Host bridge model that runs memory cycles on the nibble bus
`timescale 1ns/100ps
`default_nettype none
module lpc_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_lines,
  input wire logic i_dev_oe_n,
  output logic o_frame_strobe_n,
  output logic [3:0] o_lines,
  output logic o_drive
);
  initial begin
    o_frame_strobe_n = 1'b1;
    o_lines = 4'hf;
    o_drive = 1'b0;
  end
  // Waits a bounded time for SYNC; a silent target comes back with ok low
  task automatic cyc(input bit hub, input bit wr, input logic [3:0] sel, input logic [31:0] a,
      input logic [7:0] wd, output logic [7:0] rd, output bit ok);
    logic [3:0] q[$];
    int n;
    q.push_back(hub ? (wr ? 4'he : 4'hd) : 4'h0);
    // Plain cycle type: memory in bits 3:2, direction in bit 1
    q.push_back(hub ? sel : {2'b01, wr, 1'b0});
    for (n = hub ? 6 : 7; n >= 0; n--) q.push_back(a[n*4 +: 4]);
    if (hub) q.push_back(4'h0);
    if (wr) q.push_back(wd[3:0]);
    if (wr) q.push_back(wd[7:4]);
    q.push_back(4'hf);
    q.push_back(4'hf);
    foreach (q[i]) begin
      @(posedge i_clk);
      o_drive <= 1'b1;
      o_frame_strobe_n <= (i != 0);
      o_lines <= q[i];
    end
    @(posedge i_clk);
    o_drive <= 1'b0;
    ok = 0;
    rd = 8'h00;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge i_clk);
      ok = !i_dev_oe_n && (i_lines == 4'h0);
    end
    if (ok) begin
      @(posedge i_clk);
      rd[3:0] = i_lines;
      @(posedge i_clk);
      rd[7:4] = i_lines;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_sector_lock_gpi_device_select.sv
// Testbench for the sector lock, input pin and device select block
`timescale 1ns/100ps
`default_nettype none
module tb_sector_lock_gpi_device_select;
  import lock_gpi_pkg::*;
  logic clk = 0, rstn = 0, init_n = 1, busy = 0, pe_req = 0, clr = 0;
  logic [2:0] pe_sec = 3'h0;
  logic [3:0] straps = 4'h0;
  logic [4:0] gpi = 5'h00;
  wire logic fr_n, h_en, oe_n, awr, refd, lerr, stby;
  wire logic [3:0] h_lad, d_lad;
  wire logic [17:0] aaddr;
  wire logic [7:0] awd;
  // Lines have pull-ups, so a released bus reads f
  wire logic [3:0] lad = !oe_n ? d_lad : (h_en ? h_lad : 4'hf);
  wire logic [7:0] ard = aaddr[7:0] ^ 8'h3c;
  int mismatches = 0, n_checks = 0, cyc_n = 0, n_wr = 0, lk[7], v, k;
  logic [7:0] rd, w;
  logic [31:0] a;
  bit ok;
  logic [17:0] base[7] = '{18'h00000, 18'h10000, 18'h20000, 18'h30000, 18'h38000, 18'h3a000,
    18'h3c000};
  always #25 clk = ~clk;
  sector_lock_gpi_device_select i_dut (.i_clk(clk), .i_rstn(rstn), .i_init_n(init_n),
    .i_frame_strobe_n(fr_n), .i_muxed_addr_data_lines(lad), .o_muxed_addr_data_lines(d_lad),
    .o_muxed_addr_data_oe_n(oe_n), .i_device_select_straps(straps), .i_general_inputs(gpi),
    .i_array_rdata(ard), .i_array_busy(busy), .o_array_addr(aaddr), .o_array_wdata(awd),
    .o_array_wr(awr), .i_pe_req(pe_req), .i_pe_sector(pe_sec), .o_pe_refused(refd),
    .o_lock_error(lerr), .i_lock_error_clr(clr), .o_standby(stby));
  lpc_host_model h (.i_clk(clk), .i_lines(lad), .i_dev_oe_n(oe_n), .o_frame_strobe_n(fr_n),
    .o_lines(h_lad), .o_drive(h_en));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic lkchk(input int s);
    h.cyc(1, 0, straps, 32'hffbc0002 | base[s], 8'h00, rd, ok);
    chk("lock register", lk[s][7:0], rd);
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (awr) n_wr++;
    if (awr) w = awd;
    if (cyc_n == 20000) mismatches++;
    if (cyc_n == 20000) report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(15));
    for (k = 0; k < 7; k++) lk[k] = 1;
    repeat (20) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 7; k++) lkchk(k);
    gpi <= 5'($urandom);
    repeat (3) @(posedge clk);
    h.cyc(1, 0, straps, 32'hffbc0100, 8'h00, rd, ok);
    chk("input pins", {3'b000, gpi}, rd);
    h.cyc(1, 0, straps, 32'hffbc0004, 8'h00, rd, ok);
    chk("unmapped", 8'h00, rd);
    $display("Test reset values done");
    for (v = 0; v < 8; v++) begin
      k = v % 7;
      h.cyc(1, 1, straps, 32'hffbc0002 | base[k], 8'(v) | 8'($urandom) & 8'hf8, rd, ok);
      if (lk[k][1] == 0) lk[k] = v;
      lkchk(k);
      h.cyc(1, 1, straps, 32'hffbc0002 | base[k], 8'(~v), rd, ok);
      if (lk[k][1] == 0) lk[k] = ~v & 7;
      lkchk(k);
    end
    chk("register writes", 8'h00, 8'(n_wr));
    for (k = 0; k < 7; k++) begin
      a = 32'hfffc0000 | base[k] | 32'($urandom & 'h1fff);
      h.cyc(1, 0, straps, a, 8'h00, rd, ok);
      chk("array read", lk[k][2] ? 8'h00 : a[7:0] ^ 8'h3c, rd);
      @(posedge clk) pe_req <= 1;
      pe_sec <= 3'(k);
      @(posedge clk) pe_req <= 0;
      #1 chk("refused", 8'(lk[k][0]), 8'(refd));
      chk("lock error", 8'(lk[k][0]), 8'(lerr));
      @(posedge clk) clr <= 1;
      @(posedge clk) clr <= 0;
      @(posedge clk) #1 chk("error clear", 8'h00, 8'(lerr));
    end
    h.cyc(1, 1, straps, 32'hfffc1234, 8'ha5, rd, ok);
    chk("array write", 8'ha5, n_wr == 1 ? w : 8'hee);
    $display("Test lock table done");
    for (v = 0; v < 16; v++) begin
      @(posedge clk) straps <= 4'(v);
      gpi <= 5'($urandom);
      repeat (3) @(posedge clk);
      h.cyc(1, 0, 4'(v), 32'hffbc0100, 8'h00, rd, ok);
      chk("selected", {3'b000, gpi}, ok ? rd : 8'hee);
      h.cyc(1, 1, 4'(v) ^ 4'(1 << ($urandom % 4)), 32'hfffc0010, 8'h11, rd, ok);
      chk("foreign answer", 8'h00, 8'(ok));
      chk("standby", 8'h01, 8'(stby));
    end
    chk("foreign writes", 8'h01, 8'(n_wr));
    @(posedge clk) busy <= 1;
    @(posedge clk) #1 chk("busy standby", 8'h00, 8'(stby));
    @(posedge clk) busy <= 0;
    straps <= 4'h0;
    h.cyc(0, 0, 4'h0, 32'hff7c0100, 8'h00, rd, ok);
    chk("plain input pins", {3'b000, gpi}, rd);
    h.cyc(0, 0, 4'h0, 32'hff7c0002 | base[6], 8'h00, rd, ok);
    chk("plain lock register", lk[6][7:0], rd);
    h.cyc(0, 1, 4'h0, 32'hff801234, 8'h5a, rd, ok);
    chk("plain array write", 8'h5a, n_wr == 2 ? w : 8'hee);
    $display("Test device select done");
    @(posedge clk) init_n <= 0;
    repeat (4) @(posedge clk);
    init_n <= 1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 7; k++) lk[k] = 1;
    for (k = 0; k < 7; k++) lkchk(k);
    h.cyc(1, 1, straps, 32'hffbc0002 | base[2], 8'h03, rd, ok);
    lk[2] = 3;
    lkchk(2);
    @(posedge clk) rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    lk[2] = 1;
    lkchk(2);
    $display("Test init and reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
